/* File: rtl/enclave_gate_pkg.sv */
package enclave_gate_pkg;
   localparam logic [31:0] LEAF_FEATURES = 32'h0000_0007;
   localparam logic [31:0] LEAF_ENCLAVE = 32'h0000_0012;
   localparam int SUPPORT_FLAG_POS = 2;
   localparam int LOCK_POS = 0;
   localparam int OPT_IN_POS = 18;
   localparam int FIRST_GEN_POS = 0;
   localparam int SECOND_GEN_POS = 1;
   localparam int VIRT_CHILD_POS = 5;
   localparam int CONFLICT_POS = 6;
   localparam int MAX_SECTIONS = 2;
   localparam logic [3:0] SUBLEAF_INVALID = 4'h0;
   localparam logic [3:0] SUBLEAF_SECTION = 4'h1;
   localparam logic [31:0] FEATURE_CONTROL_RESET = 32'h0000_0000;

   typedef struct packed {
      logic [31:0] word_a;
      logic [31:0] word_b;
      logic [31:0] word_c;
      logic [31:0] word_d;
   } query_result_s;

   typedef struct packed {
      logic [31:0] leaf;
      logic [31:0] subleaf;
   } query_req_s;

   typedef enum logic [1:0] {
      OUTCOME_AVAILABLE,
      OUTCOME_INVALID_OPCODE,
      OUTCOME_GENERAL_PROTECTION
   } gate_outcome_e;
endpackage

/* File: rtl/enclave_enum_optin_gate.sv */
// Notes on behaviour
// RULE_01: Leaf 07H sub-leaf 0 word b bit 2 reports enclave support when implemented.
// RULE_02: Firmware sets opt-in bit 18 before software uses enclave resources.
// RULE_03: Opt-in bit writes follow lock rules; opted in only when both set.
// RULE_04: Opt-in bit never changes any query result.
// RULE_05: No support gives invalid opcode; missing lock or opt-in gives protection fault.
// RULE_06: With support, leaf 12H answers through its sub-leaves.
// RULE_07: Sub-leaf count depends on configuration; at least three sub-leaves non-zero.
// RULE_08: Each thread instance answers leaf 12H from its own settings.
// RULE_09: Sub-leaf 0 word a bits 0 and 1 flag first and second generation.
// RULE_10: Word a bit 5 virtual child, bit 6 conflict; other bits zero.
// RULE_11: Sub-leaf 0 word b is misc feature vector; word c zero.
// RULE_12: Word d holds size exponents in 7:0 and 15:8; upper bits zero.
// RULE_13: Sub-leaf 1 gives 128-bit attribute mask, low word first.
// RULE_14: Sub-leaves above 1 enumerate protected enclave memory sections.
// RULE_15: Sub-leaf type in bits 3:0: zero means invalid all-zero, one a section.
// RULE_16: Capability values are build-time parameters.
module enclave_enum_optin_gate
#(
   parameter bit SUPPORTED = 1'b1,
   parameter bit FIRST_GEN = 1'b1,
   parameter bit SECOND_GEN = 1'b1,
   parameter bit VIRT_CHILD = 1'b0,
   parameter bit CONFLICT = 1'b0,
   parameter logic [31:0] MISC_VECTOR = 32'h0000_0001,
   parameter logic [7:0] MAX_SIZE_LEGACY = 8'h1F,
   parameter logic [7:0] MAX_SIZE_LONG = 8'h24,
   parameter logic [127:0] ATTR_MASK = 128'h0000_0000_0000_001F_0000_0000_0000_0036,
   parameter logic [51:0] SECTION_BASE = 52'h0_0000_8000_0000,
   parameter logic [51:0] SECTION_SIZE = 52'h0_0000_0400_0000,
   parameter logic [3:0] SECTION_PROT = 4'h1
)
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rstn_in,
   // Feature control register write port
   input wire logic fc_wr_in,
   input wire logic [31:0] fc_wdata_in,
   output logic [31:0] fc_rdata_out,
   output logic fc_wr_refused_out,
   // Identification query
   input wire logic query_valid_in,
   input wire enclave_gate_pkg::query_req_s query_in,
   output logic result_valid_out,
   output enclave_gate_pkg::query_result_s result_out,
   // Enclave instruction gate
   input wire logic enclave_instr_in,
   output logic invalid_opcode_fault_out,
   output logic general_protection_fault_out,
   output logic instr_available_out,
   output enclave_gate_pkg::gate_outcome_e outcome_out
);
   import enclave_gate_pkg::*;

   logic lock_ff, nxt_lock;
   logic opt_in_ff, nxt_opt_in;
   logic refused_ff, nxt_refused;
   logic opted_in;
   gate_outcome_e outcome;

   // Like the lock, opt-in is only writable while unlocked; the write that sets lock
   // also captures opt-in, after which both stay fixed until reset.
   always_comb
   begin
      nxt_lock = lock_ff;
      nxt_opt_in = opt_in_ff;
      nxt_refused = 1'b0;
      if (fc_wr_in)
      begin
         if (!lock_ff)
         begin
            nxt_lock = fc_wdata_in[LOCK_POS]; // RULE_03
            nxt_opt_in = fc_wdata_in[OPT_IN_POS] & SUPPORTED; // RULE_03
         end
         else
         begin
            nxt_refused = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (!rstn_in)
      begin
         lock_ff <= FEATURE_CONTROL_RESET[LOCK_POS];
         opt_in_ff <= FEATURE_CONTROL_RESET[OPT_IN_POS];
         refused_ff <= 1'b0;
      end
      else
      begin
         lock_ff <= nxt_lock;
         opt_in_ff <= nxt_opt_in;
         refused_ff <= nxt_refused;
      end
   end

   always_comb
   begin
      fc_rdata_out = 32'h0000_0000;
      fc_rdata_out[LOCK_POS] = lock_ff;
      fc_rdata_out[OPT_IN_POS] = opt_in_ff;
   end
   assign fc_wr_refused_out = refused_ff;

   assign opted_in = lock_ff & opt_in_ff; // RULE_03

   always_comb
   begin
      if (!SUPPORTED)
         outcome = OUTCOME_INVALID_OPCODE; // RULE_05
      else if (!opted_in)
         outcome = OUTCOME_GENERAL_PROTECTION; // RULE_05
      else
         outcome = OUTCOME_AVAILABLE;
   end
   assign outcome_out = outcome;
   assign invalid_opcode_fault_out = enclave_instr_in && outcome == OUTCOME_INVALID_OPCODE;
   assign general_protection_fault_out =
      enclave_instr_in && outcome == OUTCOME_GENERAL_PROTECTION;
   assign instr_available_out = enclave_instr_in && outcome == OUTCOME_AVAILABLE;

   // Query answer: a pure function of parameters and request, never of opt-in, so that
   // the answer cannot reveal firmware state; each thread instance has its own copy.
   query_result_s nxt_result, result_ff;
   logic result_valid_ff;
   logic nxt_result_valid;
   logic [31:0] sect_idx;

   always_comb
   begin
      nxt_result = '0;
      nxt_result_valid = query_valid_in;
      sect_idx = query_in.subleaf - 32'h0000_0002;
      if (query_in.leaf == LEAF_FEATURES && query_in.subleaf == 32'h0000_0000)
      begin
         nxt_result.word_b[SUPPORT_FLAG_POS] = SUPPORTED; // RULE_01 RULE_04
      end
      else if (query_in.leaf == LEAF_ENCLAVE && SUPPORTED) // RULE_06 RULE_08
      begin
         if (query_in.subleaf == 32'h0000_0000)
         begin
            nxt_result.word_a[FIRST_GEN_POS] = FIRST_GEN; // RULE_09 RULE_16
            nxt_result.word_a[SECOND_GEN_POS] = SECOND_GEN; // RULE_09
            nxt_result.word_a[VIRT_CHILD_POS] = VIRT_CHILD; // RULE_10
            nxt_result.word_a[CONFLICT_POS] = CONFLICT; // RULE_10
            nxt_result.word_b = MISC_VECTOR; // RULE_11
            nxt_result.word_d = {16'h0000, MAX_SIZE_LONG, MAX_SIZE_LEGACY}; // RULE_12
         end
         else if (query_in.subleaf == 32'h0000_0001)
         begin
            nxt_result.word_a = ATTR_MASK[31:0]; // RULE_13
            nxt_result.word_b = ATTR_MASK[63:32]; // RULE_13
            nxt_result.word_c = ATTR_MASK[95:64]; // RULE_13
            nxt_result.word_d = ATTR_MASK[127:96]; // RULE_13
         end
         else if (sect_idx < 32'(MAX_SECTIONS - 1)) // RULE_14 RULE_07
         begin
            nxt_result.word_a = {SECTION_BASE[31:12], 8'h00, SUBLEAF_SECTION}; // RULE_15
            nxt_result.word_b = {12'h000, SECTION_BASE[51:32]};
            nxt_result.word_c = {SECTION_SIZE[31:12], 8'h00, SECTION_PROT};
            nxt_result.word_d = {12'h000, SECTION_SIZE[51:32]};
         end
         // Further sub-leaves stay all zero, type SUBLEAF_INVALID. RULE_15
      end
      // Between queries the last answer stands, whatever firmware writes meanwhile
      if (!query_valid_in)
      begin
         nxt_result = result_ff;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (!rstn_in)
      begin
         result_ff <= '0;
         result_valid_ff <= 1'b0;
      end
      else
      begin
         result_ff <= nxt_result;
         result_valid_ff <= nxt_result_valid;
      end
   end
   assign result_out = result_ff;
   assign result_valid_out = result_valid_ff;

   a_gate_outcome: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE_05
      enclave_instr_in |-> (instr_available_out == (SUPPORTED && lock_ff && opt_in_ff)))
      else $error("instruction gate disagrees with opt-in state");
   a_unsupported_fault: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE_05
      (enclave_instr_in && !SUPPORTED) |-> invalid_opcode_fault_out)
      else $error("unsupported instruction not invalid opcode");
   a_lock_sticks: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE_03
      lock_ff |=> (lock_ff && $stable(opt_in_ff)))
      else $error("locked feature control changed");
   a_support_flag: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE_01
      (query_valid_in && query_in.leaf == LEAF_FEATURES && query_in.subleaf == 0)
      |=> result_valid_out && result_out.word_b[SUPPORT_FLAG_POS] == SUPPORTED)
      else $error("support flag wrong");
   a_sub0_reserved: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE_10
      (query_valid_in && query_in.leaf == LEAF_ENCLAVE && query_in.subleaf == 0)
      |=> result_out.word_a[31:7] == 0 && result_out.word_a[4:2] == 0
          && result_out.word_c == 0 && result_out.word_d[31:16] == 0)
      else $error("reserved bits of sub-leaf 0 not zero");
   a_attr_mask: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE_13
      (query_valid_in && SUPPORTED && query_in.leaf == LEAF_ENCLAVE && query_in.subleaf == 1)
      |=> result_out == {ATTR_MASK[31:0], ATTR_MASK[63:32], ATTR_MASK[95:64],
                         ATTR_MASK[127:96]})
      else $error("attribute mask wrong");
   a_invalid_zero: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE_15
      (result_valid_out && result_out.word_a[3:0] == SUBLEAF_INVALID
       && $past(query_in.subleaf) > 1) |-> result_out == '0)
      else $error("invalid sub-leaf not all zero");
   a_optin_hidden: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE_04
      query_valid_in |=> result_out == $past(nxt_result))
      else $error("query result not registered from request");
   // A refused write pulses the flag once and leaves the lock standing
   sequence s_write_refused;
      fc_wr_refused_out ##1 lock_ff;
   endsequence
   a_refused_write: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE_03
      (fc_wr_in && lock_ff) |=> s_write_refused)
      else $error("locked write not refused");
   a_result_holds: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE_04
      !query_valid_in |=> $stable(result_out))
      else $error("query result changed without a query");
   a_valid_single: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE_06
      !query_valid_in |=> !result_valid_out)
      else $error("result valid without a query");
endmodule

/* File: testbench/enclave_enum_optin_gate_tb_top.sv */
module enclave_enum_optin_gate_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import enclave_gate_pkg::*;
   localparam logic [127:0] AMASK = 128'h0000_0000_0000_001F_0000_0000_0000_0036;
   localparam logic [31:0] FCM = 32'h0004_0001;
   logic clk_in = 1'b0;
   logic rstn_in = 1'b0;
   logic fc_wr_in = 1'b0;
   logic [31:0] fc_wdata_in = 32'h0000_0000;
   logic query_valid_in = 1'b0;
   query_req_s query_in = '0;
   logic enclave_instr_in = 1'b0;
   logic [31:0] fc_rdata, fc_rdata_u;
   logic refused, refused_u, res_v, res_v_u;
   query_result_s res, res_u;
   // Fault vector order: invalid opcode, protection, available
   logic [2:0] flt, flt_u;
   gate_outcome_e outc, outc_u;
   int n_fail = 0;
   int compares = 0;
   logic [31:0] rnd = 32'h0000_0006;
   always #20 clk_in = ~clk_in;
   // Second copy built without support shares every input
   enclave_enum_optin_gate #(.VIRT_CHILD(1'b1), .ATTR_MASK(AMASK)) enclave_enum_optin_gate_i (
      .clk_in(clk_in), .rstn_in(rstn_in), .fc_wr_in(fc_wr_in), .fc_wdata_in(fc_wdata_in),
      .fc_rdata_out(fc_rdata), .fc_wr_refused_out(refused), .query_valid_in(query_valid_in),
      .query_in(query_in), .result_valid_out(res_v), .result_out(res),
      .enclave_instr_in(enclave_instr_in), .invalid_opcode_fault_out(flt[2]),
      .general_protection_fault_out(flt[1]), .instr_available_out(flt[0]), .outcome_out(outc));
   enclave_enum_optin_gate #(.SUPPORTED(1'b0)) enclave_enum_optin_gate_u_i (
      .clk_in(clk_in), .rstn_in(rstn_in), .fc_wr_in(fc_wr_in), .fc_wdata_in(fc_wdata_in),
      .fc_rdata_out(fc_rdata_u), .fc_wr_refused_out(refused_u), .query_valid_in(query_valid_in),
      .query_in(query_in), .result_valid_out(res_v_u), .result_out(res_u),
      .enclave_instr_in(enclave_instr_in), .invalid_opcode_fault_out(flt_u[2]),
      .general_protection_fault_out(flt_u[1]), .instr_available_out(flt_u[0]),
      .outcome_out(outc_u));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic query_result_s exp_res(input logic [31:0] lf, input logic [31:0] sb);
      exp_res = '0;
      if (lf == LEAF_ENCLAVE)
      begin
         if (sb == 32'h0000_0000)
            exp_res = {32'h0000_0023, 32'h0000_0001, 32'h0000_0000, 32'h0000_241F};
         else if (sb == 32'h0000_0001)
            exp_res = {AMASK[31:0], AMASK[63:32], AMASK[95:64], AMASK[127:96]};
         else if (sb == 32'h0000_0002)
            exp_res = {32'h8000_0001, 32'h0000_0000, 32'h0400_0001, 32'h0000_0000};
      end
   endfunction
   task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
      compares++;
      if (g !== e)
      begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic do_reset();
      @(posedge clk_in);
      rstn_in <= 1'b0;
      repeat (6) @(posedge clk_in);
      rstn_in <= 1'b1;
      #1;
   endtask
   task automatic query(input logic [31:0] lf, input logic [31:0] sb);
      logic [1:0] sf;
      @(posedge clk_in);
      query_valid_in <= 1'b1;
      query_in <= '{leaf: lf, subleaf: sb};
      @(posedge clk_in);
      query_valid_in <= 1'b0;
      #1;
      chk("result_valid", 2'h3, {res_v, res_v_u});
      if (lf == LEAF_FEATURES)
      begin
         sf = {res.word_b[SUPPORT_FLAG_POS], res_u.word_b[SUPPORT_FLAG_POS]};
         chk("support_flag", 2'h2, sf);
      end
      else
      begin
         chk("result", exp_res(lf, sb), res);
         chk("result_unsup", '0, res_u);
      end
   endtask
   task automatic fc_write(input logic [31:0] v, input logic [31:0] e, input logic r);
      @(posedge clk_in);
      fc_wr_in <= 1'b1;
      fc_wdata_in <= v;
      @(posedge clk_in);
      fc_wr_in <= 1'b0;
      #1;
      chk("fc_rdata", e, fc_rdata);
      chk("fc_refused", r, refused);
      chk("fc_rdata_unsup", e & (32'h0000_0001 << LOCK_POS), fc_rdata_u);
      chk("fc_refused_unsup", r, refused_u);
      @(posedge clk_in);
      #1;
      chk("fc_refused_end", 1'b0, refused);
   endtask
   // Opted in only with lock and opt-in both set
   task automatic gate(input logic [31:0] fc);
      gate_outcome_e e;
      logic [2:0] ef;
      e = (fc == FCM) ? OUTCOME_AVAILABLE : OUTCOME_GENERAL_PROTECTION;
      ef = {1'b0, e == OUTCOME_GENERAL_PROTECTION, e == OUTCOME_AVAILABLE};
      @(posedge clk_in);
      enclave_instr_in <= 1'b1;
      #1;
      chk("outcome", e, outc);
      chk("faults", ef, flt);
      chk("outcome_unsup", OUTCOME_INVALID_OPCODE, outc_u);
      chk("faults_unsup", 3'h4, flt_u);
      @(posedge clk_in);
      enclave_instr_in <= 1'b0;
      #1;
      chk("faults_idle", 3'h0, flt);
   endtask
   task automatic report_and_stop();
      if (n_fail == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial
   begin
      logic [31:0] v;
      do_reset();
      gate(32'h0000_0000);
      for (int i = 0; i < 4; i++)
      begin
         rnd = lfsr(rnd);
         v = (rnd & ~FCM) | {13'h0000, i[1], 17'h0_0000, i[0]};
         do_reset();
         chk("fc_reset", 32'h0000_0000, fc_rdata);
         fc_write(v, v & FCM, 1'b0);
         gate(v & FCM);
         for (int s = 0; s < 4; s++)
            query(LEAF_ENCLAVE, 32'(s));
         query(LEAF_FEATURES, 32'h0000_0000);
         fc_write(~v, i[0] ? v & FCM : ~v & FCM, i[0]);
         gate(i[0] ? v & FCM : ~v & FCM);
      end
      for (int k = 0; k < 24; k++)
      begin
         rnd = lfsr(rnd);
         query(rnd[0] ? LEAF_ENCLAVE : {1'b1, rnd[30:0]}, {28'h000_0000, rnd[7:4]});
      end
      report_and_stop();
   end
endmodule
